// >>> hw/dual_supply_switch_sequencer_map.vh
/*
 * Constants of the dual supply switch sequencer: register offsets, field
 * positions, reset values, timing figures and counter widths.
 * Assumes a 200 MHz pclk that also serves as the internal timebase.
 */
`ifndef DUAL_SUPPLY_SWITCH_SEQUENCER_MAP_VH
`define DUAL_SUPPLY_SWITCH_SEQUENCER_MAP_VH

// ========================================================================
// clock rate
`define CLK_MHZ 200

// ========================================================================
// timing figures in their own units
`define T_UV_ON_MS 160
`define T_DEBOUNCE_MS 10
`define T_BREAKER_MS 5
`define T_BLANK_MS 5
`define T_COOL_S 4
`define T_LOCKOUT_DROP_US 12
`define T_SUPPLY_DROP_US 8
`define T_FAULT_RESET_US 20

// ========================================================================
// cycle counts of those figures at 200 MHz, sized to their counters
`define CYC_UV_ON 30'h1E84800
`define CYC_DEBOUNCE 30'h01E8480
`define CYC_BREAKER 21'h0F4240
`define CYC_BLANK 30'h00F4240
`define CYC_COOL 30'h2FAF0800
`define CYC_LOCKOUT_DROP 12'h960
`define CYC_SUPPLY_DROP 12'h640
`define CYC_FAULT_RESET 12'hFA0

// ========================================================================
// counter widths
`define SEQ_W 30
`define BRK_W 21
`define DROP_W 12
`define SEQ_ONE 30'h00000001
`define BRK_ONE 21'h000001
`define DROP_ONE 12'h001

// ========================================================================
// register byte offsets
`define ADDR_W 12
`define REG_STATE 12'h000
`define REG_INT_STATUS 12'h004
`define REG_INT_MASK 12'h008

// ========================================================================
// interrupt fields: trip ch1, trip ch2, undervoltage ch1, ch2, lockout
`define INT_W 5
`define INT_TRIP_LSB 0
`define INT_UV_LSB 2
`define INT_LOCKOUT_BIT 4
`define INT_MASK_RESET 5'h00

// ========================================================================
// state register fields
`define ST_LOCK_READY_BIT 0
`define ST_RETRY_BIT 1
`define ST_FAULT_LSB 2
`define ST_GATE_LSB 4
`define ST_CH0_LSB 8
`define ST_CH1_LSB 12

`endif

// >>> hw/pin_sync.v
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level from outside the pclk domain; the
 * first stage is read only by the second.
 */
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_val,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] stable_q;

// ========================================================================
// two stages, reset to zero then seeded from the second stage path
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_q <= {WIDTH{1'b0}};
        stable_q <= {WIDTH{1'b0}};
    end else if (ce) begin
        meta_q <= async_in;
        stable_q <= meta_q;
    end
end

// reset_val only chooses the meaning of the idle level for users
assign sync_out = stable_q ^ reset_val;

endmodule

// >>> hw/dual_supply_switch_sequencer.v
/*
 * Sequencing and fault logic of a two channel live insertion supply
 * switch, with an APB register window and one level interrupt.
 * Assumes analog comparators give levels for supply presence, lockout
 * and current limit, and that pclk is the free-running timebase.
 */
// Chosen here: the register addresses and the APB interface to the registers.
`include "dual_supply_switch_sequencer_map.vh"

module dual_supply_switch_sequencer #(
    parameter [`SEQ_W-1:0] CYC_UV_ON = `CYC_UV_ON,
    parameter [`SEQ_W-1:0] CYC_DEBOUNCE = `CYC_DEBOUNCE,
    parameter [`SEQ_W-1:0] CYC_BLANK = `CYC_BLANK,
    parameter [`SEQ_W-1:0] CYC_COOL = `CYC_COOL,
    parameter [`BRK_W-1:0] CYC_BREAKER = `CYC_BREAKER
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire chan1_enable_n,
    input wire chan2_enable_n,
    input wire chan1_supply,
    input wire chan2_supply,
    input wire supply_lockout,
    input wire chan1_current_limit_amp,
    input wire chan2_current_limit_amp,
    input wire auto_retry_sel,
    output wire chan1_gate_charge,
    output wire chan2_gate_charge,
    output wire chan1_gate_pulldown,
    output wire chan2_gate_pulldown,
    output wire fault_flag_out,
    output wire fault_flag_oe_n,
    output wire irq
);

localparam [`DROP_W-1:0] CYC_LOCK_DROP = `CYC_LOCKOUT_DROP;
localparam [`DROP_W-1:0] CYC_SUP_DROP = `CYC_SUPPLY_DROP;
localparam [`DROP_W-1:0] CYC_FLT_RESET = `CYC_FAULT_RESET;

// channel states, one-hot
localparam [3:0] ST_OFF = 4'h1;
localparam [3:0] ST_DEBOUNCE = 4'h2;
localparam [3:0] ST_ON = 4'h4;
localparam [3:0] ST_FAULT = 4'h8;

// ========================================================================
// input synchronisers
wire [7:0] sync_raw;
wire [7:0] sync_v;
wire [1:0] en_n_s;
wire [1:0] sup_s;
wire [1:0] lim_s;
wire lock_s;
wire retry_s;

pin_sync #(
    .WIDTH(8)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(sync_raw),
    .reset_val(8'h03),
    .sync_out(sync_v)
);

// enables idle high: stored inverted so reset reads as disabled
assign sync_raw = {auto_retry_sel, supply_lockout,
                   chan2_current_limit_amp, chan1_current_limit_amp,
                   chan2_supply, chan1_supply,
                   ~chan2_enable_n, ~chan1_enable_n};
assign en_n_s = sync_v[1:0];
assign sup_s = sync_v[3:2];
assign lim_s = sync_v[5:4];
assign lock_s = sync_v[6];
assign retry_s = sync_v[7];

// ========================================================================
// higher supply lockout qualification
reg [`SEQ_W-1:0] uv_on_cnt_q;
reg [`DROP_W-1:0] lock_drop_cnt_q;
reg lock_ready_q;
reg lock_lost_q;
reg retry_q;

// 160ms of good supply before turn-on
// retry strap held, delays on pclk
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        uv_on_cnt_q <= {`SEQ_W{1'b0}};
        lock_drop_cnt_q <= {`DROP_W{1'b0}};
        lock_ready_q <= 1'b0;
        lock_lost_q <= 1'b0;
        retry_q <= 1'b0;
    end else if (ce) begin
        retry_q <= retry_s;
        lock_lost_q <= 1'b0;
        if (lock_s) begin
            lock_drop_cnt_q <= {`DROP_W{1'b0}};
            if (!lock_ready_q) begin
                if (uv_on_cnt_q >= CYC_UV_ON - `SEQ_ONE) begin
                    lock_ready_q <= 1'b1;
                end else begin
                    uv_on_cnt_q <= uv_on_cnt_q + `SEQ_ONE;
                end
            end
        end else begin
            // count below-threshold time; once ready, short dips are ignored
            if (lock_drop_cnt_q >= CYC_LOCK_DROP) begin
                uv_on_cnt_q <= {`SEQ_W{1'b0}};
                lock_lost_q <= lock_ready_q;
                lock_ready_q <= 1'b0;
            end else begin
                lock_drop_cnt_q <= lock_drop_cnt_q + `DROP_ONE;
                if (!lock_ready_q) begin
                    uv_on_cnt_q <= {`SEQ_W{1'b0}};
                end
            end
        end
    end
end

// ========================================================================
// per channel sequencer
wire [1:0] trip_ev;
wire [1:0] uv_ev;
wire [1:0] fault_vec;
wire [1:0] gate_vec;
wire [7:0] state_vec;

genvar i;
generate
for (i = 0; i < 2; i = i + 1) begin : ch
    reg [3:0] state_q;
    reg [`SEQ_W-1:0] seq_cnt_q;
    reg [`BRK_W-1:0] brk_cnt_q;
    reg [`DROP_W-1:0] sup_drop_cnt_q;
    reg [`DROP_W-1:0] en_high_cnt_q;
    reg sup_ok_q;
    reg gate_q;
    reg pulldown_q;
    reg fault_q;
    reg trip_q;
    reg uv_q;
    wire start_ok;
    wire blank_done;
    wire breaker_trip;
    wire flt_reset;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_drop_cnt_q <= {`DROP_W{1'b0}};
            sup_ok_q <= 1'b0;
            uv_q <= 1'b0;
        end else if (ce) begin
            uv_q <= 1'b0;
            if (sup_s[i]) begin
                sup_drop_cnt_q <= {`DROP_W{1'b0}};
                sup_ok_q <= 1'b1;
            end else if (sup_drop_cnt_q >= CYC_SUP_DROP) begin
                uv_q <= sup_ok_q;
                sup_ok_q <= 1'b0;
            end else begin
                sup_drop_cnt_q <= sup_drop_cnt_q + `DROP_ONE;
            end
        end
    end

    // enable high time for fault reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_high_cnt_q <= {`DROP_W{1'b0}};
        end else if (ce) begin
            if (!en_n_s[i]) begin
                en_high_cnt_q <= {`DROP_W{1'b0}};
            end else if (en_high_cnt_q < CYC_FLT_RESET) begin
                en_high_cnt_q <= en_high_cnt_q + `DROP_ONE;
            end
        end
    end

    // start needs lockout, supply and enable
    assign start_ok = lock_ready_q & sup_s[i] & sup_ok_q & ~en_n_s[i];
    assign blank_done = (seq_cnt_q >= CYC_BLANK);
    assign breaker_trip = blank_done & lim_s[i] &
                          (brk_cnt_q >= CYC_BREAKER - `BRK_ONE);
    assign flt_reset = (en_high_cnt_q >= CYC_FLT_RESET);

    // channel state machine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_OFF;
            seq_cnt_q <= {`SEQ_W{1'b0}};
            brk_cnt_q <= {`BRK_W{1'b0}};
            gate_q <= 1'b0;
            pulldown_q <= 1'b1;
            fault_q <= 1'b0;
            trip_q <= 1'b0;
        end else if (ce) begin
            trip_q <= 1'b0;
            case (state_q)
                ST_OFF: begin
                    gate_q <= 1'b0;
                    pulldown_q <= 1'b1;
                    seq_cnt_q <= {`SEQ_W{1'b0}};
                    if (start_ok) begin
                        state_q <= ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (!start_ok) begin
                        state_q <= ST_OFF;
                        seq_cnt_q <= {`SEQ_W{1'b0}};
                    end else if (seq_cnt_q >= CYC_DEBOUNCE - `SEQ_ONE) begin
                        state_q <= ST_ON;
                        gate_q <= 1'b1;
                        pulldown_q <= 1'b0;
                        seq_cnt_q <= {`SEQ_W{1'b0}};
                        brk_cnt_q <= {`BRK_W{1'b0}};
                    end else begin
                        seq_cnt_q <= seq_cnt_q + `SEQ_ONE;
                    end
                end
                ST_ON: begin
                    if (!blank_done) begin
                        seq_cnt_q <= seq_cnt_q + `SEQ_ONE;
                    end
                    if (lim_s[i]) begin
                        if (brk_cnt_q < CYC_BREAKER) begin
                            brk_cnt_q <= brk_cnt_q + `BRK_ONE;
                        end
                    end else begin
                        brk_cnt_q <= {`BRK_W{1'b0}};
                    end
                    if (en_n_s[i] || !sup_ok_q || !lock_ready_q) begin
                        state_q <= ST_OFF;
                        gate_q <= 1'b0;
                        pulldown_q <= 1'b1;
                    end else if (breaker_trip) begin
                        state_q <= ST_FAULT;
                        gate_q <= 1'b0;
                        pulldown_q <= 1'b1;
                        fault_q <= 1'b1;
                        trip_q <= 1'b1;
                        seq_cnt_q <= {`SEQ_W{1'b0}};
                    end
                end
                ST_FAULT: begin
                    gate_q <= 1'b0;
                    pulldown_q <= 1'b1;
                    seq_cnt_q <= seq_cnt_q + `SEQ_ONE;
                    if (!lock_ready_q || !sup_ok_q || flt_reset) begin
                        state_q <= ST_OFF;
                        fault_q <= 1'b0;
                    end else if (retry_q &&
                                 seq_cnt_q >= CYC_COOL - `SEQ_ONE) begin
                        state_q <= ST_OFF;
                        fault_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                    gate_q <= 1'b0;
                    pulldown_q <= 1'b1;
                end
            endcase
        end
    end

    assign trip_ev[i] = trip_q;
    assign uv_ev[i] = uv_q;
    assign fault_vec[i] = fault_q;
    assign gate_vec[i] = gate_q;
    assign state_vec[4*i+3:4*i] = state_q;
end
endgenerate

// each channel drives its own gate
assign chan1_gate_charge = ch[0].gate_q;
assign chan2_gate_charge = ch[1].gate_q;
assign chan1_gate_pulldown = ch[0].pulldown_q;
assign chan2_gate_pulldown = ch[1].pulldown_q;

// ========================================================================
// shared open-drain fault flag
reg fault_oe_n_q;
reg fault_level_q;

// flag low while any fault latched
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fault_oe_n_q <= 1'b1;
        fault_level_q <= 1'b0;
    end else if (ce) begin
        fault_oe_n_q <= ~(|fault_vec);
        fault_level_q <= 1'b0;
    end
end

assign fault_flag_out = fault_level_q;
assign fault_flag_oe_n = fault_oe_n_q;

// ========================================================================
// apb slave, interrupt status and mask
reg [31:0] prdata_q;
reg pready_q;
reg pslverr_q;
reg [`INT_W-1:0] int_status_q;
reg [`INT_W-1:0] int_mask_q;
reg irq_q;
reg [31:0] rd_mux;
reg rd_err;
wire [`INT_W-1:0] int_events;
wire [`INT_W-1:0] w1c;
wire [`INT_W-1:0] int_status_d;
wire apb_setup;
wire apb_write;

assign apb_setup = psel & ~penable;
assign apb_write = psel & penable & pready_q & pwrite;
assign int_events = {lock_lost_q, uv_ev, trip_ev};
assign w1c = (apb_write && paddr == `REG_INT_STATUS) ?
             pwdata[`INT_W-1:0] : {`INT_W{1'b0}};
// a new event wins over a clear in the same cycle
assign int_status_d = (int_status_q & ~w1c) | int_events;

// read decode
always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
        `REG_STATE: begin
            rd_mux[`ST_LOCK_READY_BIT] = lock_ready_q;
            rd_mux[`ST_RETRY_BIT] = retry_q;
            rd_mux[`ST_FAULT_LSB+1:`ST_FAULT_LSB] = fault_vec;
            rd_mux[`ST_GATE_LSB+1:`ST_GATE_LSB] = gate_vec;
            rd_mux[`ST_CH0_LSB+3:`ST_CH0_LSB] = state_vec[3:0];
            rd_mux[`ST_CH1_LSB+3:`ST_CH1_LSB] = state_vec[7:4];
        end
        `REG_INT_STATUS: begin
            rd_mux[`INT_W-1:0] = int_status_q;
        end
        `REG_INT_MASK: begin
            rd_mux[`INT_W-1:0] = int_mask_q;
        end
        default: begin
            rd_err = 1'b1;
        end
    endcase
end

// bus handshake, one access cycle per transfer
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_q <= 32'h00000000;
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
        int_status_q <= {`INT_W{1'b0}};
        int_mask_q <= `INT_MASK_RESET;
        irq_q <= 1'b0;
    end else if (ce) begin
        pready_q <= apb_setup;
        if (apb_setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= rd_err;
        end else begin
            pslverr_q <= 1'b0;
        end
        if (apb_write && paddr == `REG_INT_MASK) begin
            int_mask_q <= pwdata[`INT_W-1:0];
        end
        int_status_q <= int_status_d;
        irq_q <= |(int_status_d & int_mask_q);
    end
end

assign prdata = prdata_q;
assign pready = pready_q;
assign pslverr = pslverr_q;
assign irq = irq_q;

endmodule

// >>> verif/dual_supply_switch_sequencer_assertions.sv
/*
 * Port checker of the dual supply switch sequencer.
 * Assumes only the top ports; bound to the design below.
 */
module seq_port_checker #(
    parameter int CYC_DEBOUNCE = 100,
    parameter int CYC_BREAKER = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan1_enable_n,
    input wire logic chan1_supply,
    input wire logic supply_lockout,
    input wire logic chan1_current_limit_amp,
    input wire logic chan2_current_limit_amp,
    input wire logic chan1_gate_charge,
    input wire logic chan2_gate_charge,
    input wire logic chan1_gate_pulldown,
    input wire logic chan2_gate_pulldown,
    input wire logic fault_flag_out,
    input wire logic fault_flag_oe_n
);
    // ========================================================
    // run lengths of input conditions
    int en1_q, lim1_q, lim2_q, uv1_q, lk_q;

    // count consecutive cycles of each condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en1_q <= 0;
            lim1_q <= 0;
            lim2_q <= 0;
            uv1_q <= 0;
            lk_q <= 0;
        end else begin
            en1_q <= (!chan1_enable_n && chan1_supply && supply_lockout) ? en1_q + 1 : 0;
            lim1_q <= chan1_current_limit_amp ? lim1_q + 1 : 0;
            lim2_q <= chan2_current_limit_amp ? lim2_q + 1 : 0;
            uv1_q <= chan1_supply ? 0 : uv1_q + 1;
            lk_q <= supply_lockout ? 0 : lk_q + 1;
        end
    end

    // ========================================================
    // properties
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable && ce;
    endsequence

    sequence ch1_off_s;
        chan1_enable_n [*5];
    endsequence

    gate_complement_a:
        assert property (chan1_gate_charge != chan1_gate_pulldown
            && chan2_gate_charge != chan2_gate_pulldown)
        else $error("gate charge and pulldown not complementary");
    flag_data_a:
        assert property (fault_flag_out == 1'b0)
        else $error("fault flag data not low");
    ready_answer_a:
        assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_pulse_a:
        assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a:
        assert property (pslverr |-> pready)
        else $error("slave error without ready");
    enable_off_a:
        assert property (ch1_off_s |-> !chan1_gate_charge)
        else $error("gate on with enable high");
    debounce_wait_a:
        assert property ($rose(chan1_gate_charge) |-> en1_q >= CYC_DEBOUNCE)
        else $error("gate on before debounce");
    trip_cause_a:
        assert property ($fell(fault_flag_oe_n)
            |-> lim1_q >= CYC_BREAKER || lim2_q >= CYC_BREAKER)
        else $error("fault flag without limit time");
    uv_off_a:
        assert property (uv1_q > 1620 |-> !chan1_gate_charge)
        else $error("gate on with supply low");
    lock_off_a:
        assert property (lk_q > 2420 |-> !chan1_gate_charge && !chan2_gate_charge)
        else $error("gate on after lockout loss");
endmodule

bind dual_supply_switch_sequencer seq_port_checker #(
    .CYC_DEBOUNCE(CYC_DEBOUNCE),
    .CYC_BREAKER(CYC_BREAKER)
) chk (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr, .chan1_enable_n,
    .chan1_supply, .supply_lockout, .chan1_current_limit_amp, .chan2_current_limit_amp,
    .chan1_gate_charge, .chan2_gate_charge, .chan1_gate_pulldown, .chan2_gate_pulldown,
    .fault_flag_out, .fault_flag_oe_n);

// >>> verif/supply_switch_plant.sv
/*
 * Far side of the sequencer: pass transistors and current comparators.
 * Assumes the bench commands load shorts and drives the supplies.
 */
module supply_switch_plant (
    input wire logic pclk,
    input wire logic chg1,
    input wire logic chg2,
    input wire logic short1,
    input wire logic short2,
    output logic lim1,
    output logic lim2
);
    // ========================================================
    // limit while feeding a short
    always_ff @(posedge pclk) begin
        lim1 <= chg1 & short1;
        lim2 <= chg2 & short2;
    end
endmodule

// >>> verif/dual_supply_switch_sequencer_bench.sv
/*
 * Self-checking bench of the dual supply switch sequencer.
 * Assumes the register map header and the plant model.
 */
`include "dual_supply_switch_sequencer_map.vh"
module dual_supply_switch_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UV = 200;
    localparam int DB = 100;
    localparam int BL = 50;
    localparam int CL = 400;
    localparam int BK = 50;
    typedef struct {logic rd; logic [31:0] d; logic e;} note_t;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, flag, flag_oe_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng;
    logic en1_n, en2_n, sup1, sup2, lock, lim1, lim2, retry, short1, short2;
    logic chg1, chg2, pd1, pd2;
    logic [3:0] obs;
    note_t notes[$];
    note_t nt;
    int err_count, compares, cyc, n;
    assign obs = {irq, flag_oe_n, chg2, chg1};

    // ========================================================
    // clock, design and plant
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    dual_supply_switch_sequencer #(.CYC_UV_ON(UV), .CYC_DEBOUNCE(DB), .CYC_BLANK(BL),
        .CYC_COOL(CL), .CYC_BREAKER(BK)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan1_enable_n(en1_n),
        .chan2_enable_n(en2_n), .chan1_supply(sup1), .chan2_supply(sup2),
        .supply_lockout(lock), .chan1_current_limit_amp(lim1),
        .chan2_current_limit_amp(lim2), .auto_retry_sel(retry), .chan1_gate_charge(chg1),
        .chan2_gate_charge(chg2), .chan1_gate_pulldown(pd1), .chan2_gate_pulldown(pd2),
        .fault_flag_out(flag), .fault_flag_oe_n(flag_oe_n), .irq(irq));

    supply_switch_plant plant (.pclk(pclk), .chg1(chg1), .chg2(chg2), .short1(short1),
        .short2(short2), .lim1(lim1), .lim2(lim2));

    // ========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // one transfer; expected answer noted for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        notes.push_back('{!wr, exp, err});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait until an observed pin takes a value, counting cycles
    task automatic wait_bit(input int k, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (obs[k] !== v && n < lim);
    endtask

    task finish_test;
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ========================================================
    // bus monitor and hang limit
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            if (nt.rd || nt.e)
                check(prdata, nt.d, "read data");
            check(pslverr, nt.e, "slave error");
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ========================================================
    // scenarios
    initial begin
        {ce, psel, penable, pwrite, presetn} = 5'b10000;
        paddr = 12'h000;
        pwdata = 32'h0;
        {en1_n, en2_n, sup1, sup2, lock, retry, short1, short2} = 8'hF0;
        rng = 32'hD9B4;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check(obs, 4'h4, "reset pins");
        check({pd1, pd2}, 2'h3, "reset pulldown");
        apb(0, `REG_STATE, 0, 32'h1100, 0);
        apb(0, `REG_INT_MASK, 0, 0, 0);
        rng = xs(rng);
        apb(1, 12'h00C, rng, 0, 1);
        @(posedge pclk);
        en1_n <= 1'b0;
        lock <= 1'b1;
        wait_bit(0, 1'b1, UV + DB + 30);
        check(n >= UV + DB && n < UV + DB + 30, 1, "first turn on");
        check(pd1, 0, "pulldown off");
        rng = xs(rng);
        @(posedge pclk);
        en2_n <= 1'b0;
        repeat (10 + rng % 80) @(posedge pclk);
        en2_n <= 1'b1;
        repeat (5) @(posedge pclk);
        en2_n <= 1'b0;
        wait_bit(1, 1'b1, DB + 30);
        check(n >= DB && n < DB + 30, 1, "debounce restart");
        check(chg1, 1, "other channel");
        apb(1, `REG_INT_MASK, 32'h1F, 0, 0);
        @(posedge pclk);
        short1 <= 1'b1;
        wait_bit(2, 1'b0, BL + BK + 30);
        check(n >= BK && n < BK + 30, 1, "breaker time");
        repeat (2) @(posedge pclk);
        #1;
        check(obs, 4'hA, "trip pins");
        apb(0, `REG_INT_STATUS, 0, 32'h01, 0);
        apb(1, `REG_INT_STATUS, 32'h01, 0, 0);
        repeat (600) @(posedge pclk);
        #1;
        check(obs, 4'h2, "held off");
        @(posedge pclk);
        short1 <= 1'b0;
        en1_n <= 1'b1;
        wait_bit(2, 1'b1, 4100);
        check(n >= 4000 && n < 4100, 1, "fault reset");
        @(posedge pclk);
        en1_n <= 1'b0;
        wait_bit(0, 1'b1, DB + 30);
        check(n >= DB && n < DB + 30, 1, "turn on again");
        @(posedge pclk);
        sup1 <= 1'b0;
        wait_bit(0, 1'b0, 1700);
        check(n >= 1600 && n < 1700, 1, "supply filter");
        check(chg2, 1, "other on");
        apb(0, `REG_INT_STATUS, 0, 32'h04, 0);
        @(posedge pclk);
        sup1 <= 1'b1;
        ce <= 1'b0;
        repeat (50) @(posedge pclk);
        ce <= 1'b1;
        wait_bit(0, 1'b1, DB + 30);
        check(n >= DB && n < DB + 30, 1, "supply back");
        @(posedge pclk);
        lock <= 1'b0;
        wait_bit(1, 1'b0, 2500);
        check(n >= 2400 && n < 2500, 1, "lockout loss");
        check(chg1, 0, "both off");
        @(posedge pclk);
        lock <= 1'b1;
        retry <= 1'b1;
        short2 <= 1'b1;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_bit(1, 1'b1, UV + DB + 40);
        wait_bit(2, 1'b0, BL + BK + 30);
        check(n >= BL && n < BL + BK + 30, 1, "blanking");
        @(posedge pclk);
        short2 <= 1'b0;
        wait_bit(2, 1'b1, CL + 30);
        check(n >= CL - 5 && n < CL + 30, 1, "cool down");
        wait_bit(1, 1'b1, DB + 30);
        check(n >= DB && n < DB + 30, 1, "retry turn on");
        finish_test();
    end
endmodule
